// [src/rxeq_consts.svh]
// Offsets, field positions, reset values and timing counts of the per-port equalizer debug bank.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef RXEQ_CONSTS_SVH
`define RXEQ_CONSTS_SVH
`define RXEQ_PORT_SEL_ADDR 8'h4C
`define RXEQ_RSVD_LO_ADDR 8'hC0
`define RXEQ_RSVD_HI_ADDR 8'hCF
`define RXEQ_DEBUG_ADDR 8'hD0
`define RXEQ_RSVD_D1_ADDR 8'hD1
`define RXEQ_CTL2_ADDR 8'hD2
`define RXEQ_STATUS_ADDR 8'hD3
`define RXEQ_BYPASS_ADDR 8'hD4
`define RXEQ_LIMITS_ADDR 8'hD5
`define RXEQ_RSVD_D1_VALUE 8'h43
`define RXEQ_PORT_SEL_RESET 8'h0F
`define RXEQ_CTL2_RESET 8'h94
`define RXEQ_BYPASS_RESET 8'h60
`define RXEQ_LIMITS_RESET 8'hF2
`define RXEQ_DEBUG_SELFTEST_BIT 5
`define RXEQ_DEBUG_CONT_BIT 1
`define RXEQ_DEBUG_SINGLE_BIT 0
`define RXEQ_CTL2_FIRST_LOCK_BIT 4
`define RXEQ_CTL2_RESTART_BIT 3
`define RXEQ_CTL2_FLOOR_BIT 2
`define RXEQ_BYPASS_LOCK_MODE_BIT 4
`define RXEQ_BYPASS_DISABLE_BIT 0
// Shortest relock wait, 164 us; longer codes double it
`define RXEQ_RELOCK_BASE_NS 164000
`define RXEQ_CLK_PERIOD_NS 10
`define RXEQ_RELOCK_BASE_CYCLES (`RXEQ_RELOCK_BASE_NS / `RXEQ_CLK_PERIOD_NS)
`endif

// [src/rxeq_pkg.sv]
// Types shared by the equalizer debug bank modules.
// Assumes the constants header is included where offsets are needed.
package rxeq_pkg;
	// Gray-coded adaptation states along idle, wait, done, hold
	typedef enum logic [1:0] {
		RXEQ_IDLE = 2'b00,
		RXEQ_WAIT = 2'b01,
		RXEQ_DONE = 2'b11,
		RXEQ_HOLD = 2'b10
	} rxeq_state_type;
	typedef struct packed {
		logic [7:0] debug_ctl;
		logic [7:0] ctl2;
		logic [7:0] bypass;
		logic [7:0] limits;
	} rxeq_regs_type;
endpackage

// [src/rxeq_adapt.sv]
// Adaptive equalizer stepping engine for one receive port.
// Assumes the lock input synchronous to core_clk.
`timescale 1ns/10ps
`include "rxeq_consts.svh"
module rxeq_adapt
	import rxeq_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [2:0] relock_code,
	input wire logic first_lock_restart,
	input wire logic restart,
	input wire logic floor_enable,
	input wire logic [3:0] floor_setting,
	input wire logic [3:0] max_setting,
	input wire logic adapt_disable,
	input wire logic lock_mode,
	input wire logic [5:0] manual_setting,
	input wire logic cdr_lock,
	output logic [5:0] eq_setting,
	output logic [5:0] eq_state,
	output logic rx_lock
);
	typedef struct packed {
		rxeq_state_type state;
		logic [3:0] level;
		logic [21:0] count;
		logic prev_lock;
		logic seen_lock;
		logic [5:0] setting;
		logic lock;
	} rxeq_adapt_type;
	rxeq_adapt_type cur;
	rxeq_adapt_type next_cur;
	logic [21:0] wait_cycles;
	logic [3:0] start_level;

	// Wait length doubles per code; 164 us base times 2^code
	assign wait_cycles = 22'(`RXEQ_RELOCK_BASE_CYCLES) << relock_code;
	assign start_level = floor_enable ? floor_setting : 4'h0;

	// Next-state logic of the stepping engine
	always_comb begin
		next_cur = cur;
		next_cur.prev_lock = cdr_lock;
		if (restart || (first_lock_restart && cdr_lock && !cur.seen_lock)) begin
			next_cur.level = start_level;
			next_cur.count = 22'h0;
			next_cur.state = RXEQ_WAIT;
		end else begin
			case (cur.state)
				RXEQ_IDLE: begin
					next_cur.level = start_level;
					next_cur.state = RXEQ_WAIT;
				end
				RXEQ_WAIT: begin
					if (cdr_lock) begin
						next_cur.state = RXEQ_DONE;
					end else if (cur.count + 22'h1 >= wait_cycles) begin
						next_cur.count = 22'h0;
						// Step up one, never above max; wrap to start to keep searching
						if (cur.level < max_setting) begin
							next_cur.level = cur.level + 4'h1;
						end else begin
							next_cur.level = start_level;
						end
					end else begin
						next_cur.count = cur.count + 22'h1;
					end
				end
				RXEQ_DONE: begin
					if (!cdr_lock) begin
						next_cur.count = 22'h0;
						next_cur.state = RXEQ_WAIT;
					end
				end
				default: next_cur.state = RXEQ_IDLE;
			endcase
		end
		if (cdr_lock) begin
			next_cur.seen_lock = 1'b1;
		end
		// Bypass overrides the adaptive result with the manual fields
		next_cur.setting = adapt_disable ? manual_setting : {2'h0, cur.level};
		next_cur.lock = lock_mode ? (cdr_lock && (adapt_disable || cur.state == RXEQ_DONE))
			: cdr_lock;
	end

	// State register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign eq_setting = cur.setting;
	assign eq_state = {1'b0, cur.state, cur.level[2:0]};
	assign rx_lock = cur.lock;

	// A lowered maximum takes hold at the next step; a step never lands above it
	property p_max_bound;
		@(posedge core_clk) disable iff (!arst_n)
		(cur.level == $past(cur.level) + 4'h1 && cur.level != 4'h0 && !$past(restart))
			|-> (cur.level <= $past(max_setting));
	endproperty
	a_max_bound: assert property (p_max_bound) else $error("level above maximum");

	property p_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		adapt_disable |=> (eq_setting == $past(manual_setting));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass setting wrong");

	property p_restart;
		@(posedge core_clk) disable iff (!arst_n)
		restart |=> (cur.level == $past(start_level) && cur.state == RXEQ_WAIT);
	endproperty
	a_restart: assert property (p_restart) else $error("restart missed");

	property p_lock_mode;
		@(posedge core_clk) disable iff (!arst_n)
		(!lock_mode && !cdr_lock) |=> !rx_lock;
	endproperty
	a_lock_mode: assert property (p_lock_mode) else $error("lock without circuit");
endmodule

// [src/rxeq_bc_inject.sv]
// Back-channel error injector for one receive port.
// Assumes a frame strobe of one cycle per outgoing back-channel frame.
`timescale 1ns/10ps
module rxeq_bc_inject
	import rxeq_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic continuous,
	input wire logic single_set,
	input wire logic frame_strobe,
	output logic single_pending,
	output logic corrupt
);
	typedef struct packed {
		logic pending;
		logic corrupt;
	} rxeq_inj_type;
	rxeq_inj_type cur;
	rxeq_inj_type next_cur;

	// Set wins over the self-clear so a write during a frame is kept
	always_comb begin
		next_cur = cur;
		next_cur.corrupt = frame_strobe && (continuous || cur.pending);
		if (single_set) begin
			next_cur.pending = 1'b1;
		end else if (frame_strobe) begin
			next_cur.pending = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign single_pending = cur.pending;
	assign corrupt = cur.corrupt;

	property p_single;
		@(posedge core_clk) disable iff (!arst_n)
		(cur.pending && frame_strobe && !single_set) |=> (!cur.pending && corrupt);
	endproperty
	a_single: assert property (p_single) else $error("single error not issued");

	property p_cont;
		@(posedge core_clk) disable iff (!arst_n)
		(frame_strobe && continuous) |=> corrupt;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous error missed");

	property p_quiet;
		@(posedge core_clk) disable iff (!arst_n)
		(!frame_strobe) |=> !corrupt;
	endproperty
	a_quiet: assert property (p_quiet) else $error("corrupt outside frame");
endmodule

// [src/rxeq_regs.sv]
// Paged per-port debug and adaptive equalizer register bank.
// Assumes a byte-wide register port from the I2C target decoder, synchronous to core_clk.
`timescale 1ns/10ps
`include "rxeq_consts.svh"
module rxeq_regs
	import rxeq_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [3:0] partner_selftest_active,
	input wire logic [3:0] cdr_lock,
	input wire logic [3:0] bc_frame_strobe,
	output logic [3:0] bc_corrupt,
	output logic [23:0] eq_setting,
	output logic [3:0] rx_lock
);
	typedef struct packed {
		logic [7:0] receive_port_select;
		rxeq_regs_type [3:0] port;
		logic [7:0] rdata;
		logic rvalid;
	} rxeq_bank_type;
	rxeq_bank_type cur;
	rxeq_bank_type next_cur;
	logic [3:0] single_pending;
	logic [3:0] restart_pulse;
	logic [3:0] single_set;
	logic [23:0] eq_state;
	logic [1:0] rd_port;
	logic [3:0] wr_mask;
	logic [7:0] rd_word;

	assign rd_port = cur.receive_port_select[5:4];
	assign wr_mask = cur.receive_port_select[3:0];

	// Per-port engines; one copy of each paged register per port
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			assign restart_pulse[gi] = cur.port[gi].ctl2[`RXEQ_CTL2_RESTART_BIT];
			assign single_set[gi] = reg_wr && wr_mask[gi] && reg_addr == `RXEQ_DEBUG_ADDR
				&& reg_wdata[`RXEQ_DEBUG_SINGLE_BIT];
			rxeq_adapt u_adapt (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.relock_code(cur.port[gi].ctl2[7:5]),
				.first_lock_restart(cur.port[gi].ctl2[`RXEQ_CTL2_FIRST_LOCK_BIT]),
				.restart(restart_pulse[gi]),
				.floor_enable(cur.port[gi].ctl2[`RXEQ_CTL2_FLOOR_BIT]),
				.floor_setting(cur.port[gi].limits[3:0]),
				.max_setting(cur.port[gi].limits[7:4]),
				.adapt_disable(cur.port[gi].bypass[`RXEQ_BYPASS_DISABLE_BIT]),
				.lock_mode(cur.port[gi].bypass[`RXEQ_BYPASS_LOCK_MODE_BIT]),
				.manual_setting({cur.port[gi].bypass[7:5], cur.port[gi].bypass[3:1]}),
				.cdr_lock(cdr_lock[gi]),
				.eq_setting(eq_setting[gi*6 +: 6]),
				.eq_state(eq_state[gi*6 +: 6]),
				.rx_lock(rx_lock[gi])
			);
			rxeq_bc_inject u_inject (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.continuous(cur.port[gi].debug_ctl[`RXEQ_DEBUG_CONT_BIT]),
				.single_set(single_set[gi]),
				.frame_strobe(bc_frame_strobe[gi]),
				.single_pending(single_pending[gi]),
				.corrupt(bc_corrupt[gi])
			);
		end
	endgenerate

	// Read mux for the selected port; unknown addresses and the reserved block read zero
	always_comb begin
		rd_word = 8'h00;
		if (reg_addr == `RXEQ_PORT_SEL_ADDR) begin
			rd_word = cur.receive_port_select;
		end else if (reg_addr >= `RXEQ_RSVD_LO_ADDR && reg_addr <= `RXEQ_RSVD_HI_ADDR) begin
			rd_word = 8'h00;
		end else begin
			case (reg_addr)
				`RXEQ_DEBUG_ADDR: rd_word = {2'h0, partner_selftest_active[rd_port], 3'h0,
					cur.port[rd_port].debug_ctl[1], single_pending[rd_port]};
				`RXEQ_RSVD_D1_ADDR: rd_word = `RXEQ_RSVD_D1_VALUE;
				`RXEQ_CTL2_ADDR: rd_word = {cur.port[rd_port].ctl2[7:4], 1'b0,
					cur.port[rd_port].ctl2[2], 2'h0};
				`RXEQ_STATUS_ADDR: rd_word = {2'h0, eq_state[rd_port*6 +: 6]};
				`RXEQ_BYPASS_ADDR: rd_word = cur.port[rd_port].bypass;
				`RXEQ_LIMITS_ADDR: rd_word = cur.port[rd_port].limits;
				default: rd_word = 8'h00;
			endcase
		end
	end

	// Register writes, restart self-clear and read data capture
	always_comb begin
		next_cur = cur;
		next_cur.rvalid = reg_rd;
		next_cur.rdata = reg_rd ? rd_word : cur.rdata;
		for (int i = 0; i < 4; i++) begin
			next_cur.port[i].ctl2[`RXEQ_CTL2_RESTART_BIT] = 1'b0;
			if (reg_wr && wr_mask[i]) begin
				case (reg_addr)
					`RXEQ_DEBUG_ADDR: next_cur.port[i].debug_ctl = {6'h00,
						reg_wdata[`RXEQ_DEBUG_CONT_BIT], 1'b0};
					`RXEQ_CTL2_ADDR: next_cur.port[i].ctl2 = {reg_wdata[7:2], 2'h0};
					`RXEQ_BYPASS_ADDR: next_cur.port[i].bypass = reg_wdata;
					`RXEQ_LIMITS_ADDR: next_cur.port[i].limits = reg_wdata;
					default: next_cur.port[i] = next_cur.port[i];
				endcase
			end
		end
		if (reg_wr && reg_addr == `RXEQ_PORT_SEL_ADDR) begin
			next_cur.receive_port_select = reg_wdata;
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur.receive_port_select <= `RXEQ_PORT_SEL_RESET;
			for (int i = 0; i < 4; i++) begin
				cur.port[i].debug_ctl <= 8'h00;
				cur.port[i].ctl2 <= `RXEQ_CTL2_RESET;
				cur.port[i].bypass <= `RXEQ_BYPASS_RESET;
				cur.port[i].limits <= `RXEQ_LIMITS_RESET;
			end
			cur.rdata <= 8'h00;
			cur.rvalid <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata = cur.rdata;
	assign reg_rvalid = cur.rvalid;

	property p_rsvd_zero;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr >= 8'hC0 && reg_addr <= 8'hCF) |=> (reg_rvalid && reg_rdata == 8'h00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved block not zero");

	property p_read_page;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_LIMITS_ADDR)
			|=> (reg_rdata == $past(cur.port[rd_port].limits));
	endproperty
	a_read_page: assert property (p_read_page) else $error("wrong port read");

	property p_write_mask;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_BYPASS_ADDR && !wr_mask[0])
			|=> $stable(cur.port[0].bypass);
	endproperty
	a_write_mask: assert property (p_write_mask) else $error("unselected port written");

	property p_restart_clear;
		@(posedge core_clk) disable iff (!arst_n)
		restart_pulse[0] |=> !restart_pulse[0];
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("restart stuck");

	property p_selftest;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_DEBUG_ADDR)
			|=> (reg_rdata[5] == $past(partner_selftest_active[rd_port]));
	endproperty
	a_selftest: assert property (p_selftest) else $error("self-test flag wrong");

	// Every read strobe is answered on the next cycle
	property p_rvalid_pulse;
		@(posedge core_clk) disable iff (!arst_n)
		reg_rd
			|=> reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

	// No answer without a read strobe
	property p_rvalid_quiet;
		@(posedge core_clk) disable iff (!arst_n)
		!reg_rd
			|=> !reg_rvalid;
	endproperty
	a_rvalid_quiet: assert property (p_rvalid_quiet) else $error("answer without read");

	// Read data holds between reads so a slow host can still pick it up
	property p_rdata_hold;
		@(posedge core_clk) disable iff (!arst_n)
		!reg_rd
			|=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	// Bypass reads come from the read-selected port
	property p_read_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_BYPASS_ADDR)
			|=> (reg_rdata == $past(cur.port[rd_port].bypass));
	endproperty
	a_read_bypass: assert property (p_read_bypass) else $error("bypass read wrong port");

	// The select register itself is not paged
	property p_read_sel;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_PORT_SEL_ADDR)
			|=> (reg_rdata == $past(cur.receive_port_select));
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("select read wrong");

	// A select write takes effect for the next access
	property p_write_sel;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_PORT_SEL_ADDR)
			|=> (cur.receive_port_select == $past(reg_wdata));
	endproperty
	a_write_sel: assert property (p_write_sel) else $error("select not written");

	// An enabled port takes the limits byte
	property p_write_limits;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_LIMITS_ADDR && wr_mask[1])
			|=> (cur.port[1].limits == $past(reg_wdata));
	endproperty
	a_write_limits: assert property (p_write_limits) else $error("enabled port missed");

	// A port without its write enable keeps its limits
	property p_mask_limits;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_LIMITS_ADDR && !wr_mask[3])
			|=> $stable(cur.port[3].limits);
	endproperty
	a_mask_limits: assert property (p_mask_limits) else $error("masked port written");

	// Bypass byte lands whole, disable bit and manual fields together
	property p_write_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_BYPASS_ADDR && wr_mask[2])
			|=> (cur.port[2].bypass == $past(reg_wdata));
	endproperty
	a_write_bypass: assert property (p_write_bypass) else $error("bypass not written");

	// Reserved debug bits read zero
	property p_debug_layout;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_DEBUG_ADDR)
			|=> (reg_rdata[7:6] == 2'h0 && reg_rdata[4:2] == 3'h0);
	endproperty
	a_debug_layout: assert property (p_debug_layout) else $error("debug reserved set");

	// Continuous injection bit reads back per port
	property p_read_cont;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_DEBUG_ADDR)
			|=> (reg_rdata[1] == $past(cur.port[rd_port].debug_ctl[1]));
	endproperty
	a_read_cont: assert property (p_read_cont) else $error("continuous bit wrong");

	// Single injection bit reads one until a frame consumes it
	property p_read_single;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_DEBUG_ADDR)
			|=> (reg_rdata[0] == $past(single_pending[rd_port]));
	endproperty
	a_read_single: assert property (p_read_single) else $error("single bit wrong");

	// A single-error write arms the injector
	property p_single_arm;
		@(posedge core_clk) disable iff (!arst_n)
		single_set[0]
			|=> single_pending[0];
	endproperty
	a_single_arm: assert property (p_single_arm) else $error("single error not armed");

	// Continuous bit follows the written value
	property p_cont_write;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_DEBUG_ADDR && wr_mask[0])
			|=> (cur.port[0].debug_ctl[1] == $past(reg_wdata[1]));
	endproperty
	a_cont_write: assert property (p_cont_write) else $error("continuous not written");

	// A restart write reaches the engine on the next cycle
	property p_restart_arm;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr == `RXEQ_CTL2_ADDR && wr_mask[2] && reg_wdata[3])
			|=> restart_pulse[2];
	endproperty
	a_restart_arm: assert property (p_restart_arm) else $error("restart not issued");

	// Restart and reserved bits of control two read zero
	property p_ctl2_layout;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_CTL2_ADDR)
			|=> (reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0);
	endproperty
	a_ctl2_layout: assert property (p_ctl2_layout) else $error("control two layout");

	// Status top bits are reserved
	property p_status_layout;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_STATUS_ADDR)
			|=> (reg_rdata[7:6] == 2'h0);
	endproperty
	a_status_layout: assert property (p_status_layout) else $error("status top bits");

	// Status shows the engine of the read-selected port
	property p_status_page;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_STATUS_ADDR)
			|=> (reg_rdata[5:0] == $past(eq_state[rd_port*6 +: 6]));
	endproperty
	a_status_page: assert property (p_status_page) else $error("status wrong port");

	// The fixed reserved byte reads its constant
	property p_rsvd_d1;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr == `RXEQ_RSVD_D1_ADDR)
			|=> (reg_rdata == `RXEQ_RSVD_D1_VALUE);
	endproperty
	a_rsvd_d1: assert property (p_rsvd_d1) else $error("reserved byte wrong");

	// Addresses past the bank read zero
	property p_unmapped;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_rd && reg_addr > `RXEQ_LIMITS_ADDR)
			|=> (reg_rdata == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

	// Writes to the reserved block change nothing
	property p_rsvd_write;
		@(posedge core_clk) disable iff (!arst_n)
		(reg_wr && reg_addr >= `RXEQ_RSVD_LO_ADDR && reg_addr <= `RXEQ_RSVD_HI_ADDR)
			|=> ($stable(cur.receive_port_select) && $stable(cur.port[0].bypass));
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write acted");
endmodule

// [verification/rxeq_far_end.sv]
// Far-end back-channel model: sends frame strobes and counts corrupted frames.
// Assumes one-cycle requests from the bench, synchronous to core_clk.
`timescale 1ns/10ps
module rxeq_far_end (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [3:0] frame_req,
	input wire logic [3:0] bc_corrupt,
	output logic [3:0] bc_frame_strobe,
	output logic [15:0] hits
);
	// One strobe per request; corrupt pulses are tallied per port, four bits each
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bc_frame_strobe <= 4'h0;
			hits <= 16'h0000;
		end else begin
			bc_frame_strobe <= frame_req;
			for (int n = 0; n < 4; n++) begin
				if (bc_corrupt[n]) begin
					hits[4*n +: 4] <= hits[4*n +: 4] + 4'h1;
				end
			end
		end
	end
endmodule

// [verification/tb_rx_port_equalizer_debug_regs.sv]
// Self-checking bench for the paged equalizer debug bank.
// Assumes the register port contract: one-cycle strobes, read answer one cycle later.
`timescale 1ns/10ps
`include "rxeq_consts.svh"
module tb_rx_port_equalizer_debug_regs;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [3:0] selftest = 4'h0;
	logic [3:0] cdr_lock = 4'h0;
	logic [3:0] frame_req = 4'h0;
	logic [3:0] strobe;
	logic [3:0] bc_corrupt;
	logic [23:0] eq_setting;
	logic [3:0] rx_lock;
	logic [15:0] hits;
	int fails = 0;
	int checked = 0;

	always #5 core_clk = ~core_clk;

	rxeq_regs dut (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .partner_selftest_active(selftest), .cdr_lock(cdr_lock),
		.bc_frame_strobe(strobe), .bc_corrupt(bc_corrupt), .eq_setting(eq_setting),
		.rx_lock(rx_lock));
	rxeq_far_end far (.core_clk(core_clk), .arst_n(arst_n), .frame_req(frame_req),
		.bc_corrupt(bc_corrupt), .bc_frame_strobe(strobe), .hits(hits));

	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
	endtask

	// The valid flag stands for one cycle only, so it is sampled right after the take edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		chk("read valid", {23'h0, reg_rvalid}, 24'h1);
		chk($sformatf("read %h", a), {16'h0, reg_rdata}, {16'h0, exp});
	endtask

	task automatic frame(input logic [3:0] m);
		@(posedge core_clk);
		#1 frame_req = m;
		@(posedge core_clk);
		#1 frame_req = 4'h0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic endt(input string name);
		$display("test %s done", name);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog: the stepping test needs about 33000 cycles, so 50000 leaves room
	initial begin
		#500000;
		fails++;
		test_done;
	end

	initial begin
		logic [7:0] s;
		repeat (2) @(posedge core_clk);
		#1 arst_n = 1'b1;
		// Reset values, reserved and unmapped places
		rd(`RXEQ_PORT_SEL_ADDR, 8'h0F);
		rd(`RXEQ_DEBUG_ADDR, 8'h00);
		rd(`RXEQ_RSVD_D1_ADDR, 8'h43);
		rd(`RXEQ_CTL2_ADDR, 8'h94);
		rd(`RXEQ_BYPASS_ADDR, 8'h60);
		rd(`RXEQ_LIMITS_ADDR, 8'hF2);
		// Port 0 is waiting for lock at the floor level 2
		rd(`RXEQ_STATUS_ADDR, 8'h0A);
		chk("status top bits", {16'h0, reg_rdata & 8'hC0}, 24'h0);
		chk("start setting", {18'h0, eq_setting[5:0]}, 24'h2);
		wr(`RXEQ_RSVD_LO_ADDR, 8'h5A);
		rd(`RXEQ_RSVD_LO_ADDR, 8'h00);
		rd(`RXEQ_RSVD_HI_ADDR, 8'h00);
		rd(8'hE0, 8'h00);
		wr(`RXEQ_STATUS_ADDR, 8'hFF);
		rd(`RXEQ_STATUS_ADDR, 8'h0A);
		endt("reset");
		// Each port written alone, then read back through the read selector
		for (int p = 0; p < 4; p++) begin
			s = (8'h01 << p) | 8'(p << 4);
			wr(`RXEQ_PORT_SEL_ADDR, s);
			wr(`RXEQ_BYPASS_ADDR, 8'h02 << p);
		end
		for (int p = 0; p < 4; p++) begin
			wr(`RXEQ_PORT_SEL_ADDR, 8'(p << 4));
			rd(`RXEQ_BYPASS_ADDR, 8'h02 << p);
		end
		wr(`RXEQ_PORT_SEL_ADDR, 8'h0F);
		wr(`RXEQ_BYPASS_ADDR, 8'h60);
		endt("paging");
		// Partner self-test flag is per port and cannot be written
		selftest = 4'b0100;
		wr(`RXEQ_DEBUG_ADDR, 8'h20);
		for (int p = 0; p < 4; p++) begin
			wr(`RXEQ_PORT_SEL_ADDR, 8'(p << 4));
			rd(`RXEQ_DEBUG_ADDR, (p == 2) ? 8'h20 : 8'h00);
		end
		endt("selftest");
		// Single error is consumed by one frame, continuous hits every frame
		wr(`RXEQ_PORT_SEL_ADDR, 8'h01);
		wr(`RXEQ_DEBUG_ADDR, 8'h01);
		rd(`RXEQ_DEBUG_ADDR, 8'h01);
		frame(4'h1);
		frame(4'h1);
		chk("single hits", {8'h0, hits}, 24'h1);
		rd(`RXEQ_DEBUG_ADDR, 8'h00);
		wr(`RXEQ_DEBUG_ADDR, 8'h02);
		frame(4'h1);
		frame(4'h1);
		frame(4'h1);
		chk("continuous hits", {8'h0, hits}, 24'h4);
		wr(`RXEQ_DEBUG_ADDR, 8'h00);
		frame(4'h1);
		chk("stopped hits", {8'h0, hits}, 24'h4);
		endt("backchannel");
		// Manual setting in bypass, then back to adaptation from a new floor
		wr(`RXEQ_BYPASS_ADDR, 8'hAB);
		repeat (3) @(posedge core_clk);
		chk("manual setting", {18'h0, eq_setting[5:0]}, 24'h2D);
		wr(`RXEQ_BYPASS_ADDR, 8'h60);
		wr(`RXEQ_PORT_SEL_ADDR, 8'h0F);
		wr(`RXEQ_LIMITS_ADDR, 8'hF5);
		wr(`RXEQ_CTL2_ADDR, 8'h9C);
		repeat (3) @(posedge core_clk);
		chk("floor setting", {18'h0, eq_setting[5:0]}, 24'h5);
		rd(`RXEQ_CTL2_ADDR, 8'h94);
		endt("equalizer");
		// Lock from the lock circuit alone while lock mode is clear
		#1 cdr_lock = 4'b0010;
		repeat (2) @(posedge core_clk);
		#1 chk("lock on", {20'h0, rx_lock}, 24'h2);
		cdr_lock = 4'b0000;
		repeat (2) @(posedge core_clk);
		#1 chk("lock off", {20'h0, rx_lock}, 24'h0);
		// With lock mode set, lock waits one more cycle for the engine to finish
		wr(`RXEQ_BYPASS_ADDR, 8'h70);
		cdr_lock = 4'b0010;
		@(posedge core_clk);
		#1 chk("lock held for adapt", {20'h0, rx_lock}, 24'h0);
		@(posedge core_clk);
		#1 chk("lock after adapt", {20'h0, rx_lock}, 24'h2);
		cdr_lock = 4'b0000;
		wr(`RXEQ_BYPASS_ADDR, 8'h60);
		endt("lock");
		// Shortest wait: one step up to the maximum, then back to the start
		wr(`RXEQ_LIMITS_ADDR, 8'h32);
		wr(`RXEQ_CTL2_ADDR, 8'h1C);
		repeat (3) @(posedge core_clk);
		chk("restart level", {18'h0, eq_setting[5:0]}, 24'h2);
		repeat (16420) @(posedge core_clk);
		chk("stepped level", {18'h0, eq_setting[5:0]}, 24'h3);
		repeat (16400) @(posedge core_clk);
		chk("bounded level", {18'h0, eq_setting[5:0]}, 24'h2);
		endt("stepping");
		test_done;
	end
endmodule
